// ==== verilog/irq_queue_pkg.sv ====
// Purpose: constants shared by the event status and queue sizing logic
// Assumes: Wishbone slave with 32-bit data, register byte address = 4 x index
// Notes: registers hold 16 bits in the low half of the word
package irq_queue_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int REG_W = 16;
	localparam int IDX_W = 6;
	localparam int ADDR_W = 24;
	localparam int WORDS_W = 11;
	localparam int EVENT_BITS = 14;

	// register indices
	localparam logic [IDX_W-1:0] IDX_QUEUE_SIZE = 6'h36;
	localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 6'h38;
	localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 6'h3a;

	// reset values and writable bits
	localparam logic [REG_W-1:0] QUEUE_SIZE_RESET = 16'h0000;
	localparam logic [REG_W-1:0] QUEUE_SIZE_WMASK = 16'h80ff;
	localparam logic [REG_W-1:0] EVENT_MASK_RESET = 16'hffff;

	// queue size fields
	localparam int CI_LSB = 0;
	localparam int MON_LSB = 2;
	localparam int LINE_LSB = 5;
	localparam int TIMEBASE_SEL_BIT = 15;
	localparam logic [WORDS_W-1:0] CI_UNIT_WORDS = 11'h040;
	localparam logic [WORDS_W-1:0] QUEUE_UNIT_WORDS = 11'h080;
	localparam logic [ADDR_W-1:0] QUEUE_AREA_OFFSET = 24'h000100;
	localparam logic [7:0] BASE_LOW_BYTE = 8'h00;
	localparam logic [15:0] FAULT_LIMIT = 16'h00ff;

	// event flag positions
	localparam int EV_LINE = 0;
	localparam int EV_CI_RX = 1;
	localparam int EV_MON_RX = 2;
	localparam int EV_MON_TX = 3;
	localparam int EV_CIRC = 4;
	localparam int EV_RX_WARN = 5;
	localparam int EV_RX_OVL = 6;
	localparam int EV_TX_WARN = 7;
	localparam int EV_TX_OVL = 8;
	localparam int EV_EV_WARN = 9;
	localparam int EV_EV_OVL = 10;
	localparam int EV_TIMER = 11;
	localparam int EV_SEQ = 12;
	localparam int EV_FAULT = 13;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;
endpackage

// ==== verilog/event_flag_if.sv ====
`timescale 1ns/1ps
// Purpose: carries set pulses, clear request and flags between modules
// Assumes: one clock domain
// Notes: keeper side owns the flags
interface event_flag_if #(parameter int W = 14);
	logic [W-1:0] set_pulse;
	logic clear_all;
	logic [W-1:0] flags;
	modport keeper(input set_pulse, input clear_all, output flags);
	modport user(output set_pulse, output clear_all, input flags);
endinterface

// ==== verilog/event_flags.sv ====
`timescale 1ns/1ps
// Purpose: sticky event flags with a common clear
// Assumes: set and clear are one-cycle requests on i_clk
// Notes: a set in the clearing cycle survives the clear
module event_flags #(
	parameter int W = 14
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	event_flag_if.keeper flag_bus
);
	// ----------------------------------------
	// flag cells
	// ----------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_flag
		logic flag_q;
		// set is applied after clear so an event is never lost
		always_ff @(posedge i_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				flag_q <= 1'b0;
			end else if (flag_bus.set_pulse[i]) begin
				flag_q <= 1'b1;
			end else if (flag_bus.clear_all) begin
				flag_q <= 1'b0;
			end
		end
		assign flag_bus.flags[i] = flag_q;

		a_set_wins: assert property (@(posedge i_clk) disable iff (!i_reset_n)
			flag_bus.set_pulse[i] |=> flag_q)
			else $error("flag lost its set");
	end
endmodule

// ==== verilog/irq_queue_status.sv ====
`timescale 1ns/1ps
// Purpose: queue sizing, time base select and clear-on-read event status
// Assumes: event inputs are one-cycle or level requests on i_clk
// Notes: all registers answer one cycle after the request is seen
module irq_queue_status
	import irq_queue_pkg::*;
#(
	parameter int TX_CH = 32,
	parameter int RX_CH = 32,
	parameter int CI_CH = 16,
	parameter int MON_CH = 16,
	parameter int FIFO_DEPTH = 32,
	parameter int LVL_W = $clog2(FIFO_DEPTH + 1)
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [irq_queue_pkg::ADR_W-1:0] i_wb_adr,
	input wire logic [irq_queue_pkg::DAT_W-1:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [irq_queue_pkg::DAT_W-1:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [TX_CH-1:0] i_line_tx_event,
	input wire logic [RX_CH-1:0] i_line_rx_event,
	input wire logic [CI_CH-1:0] i_ci_rx_event,
	input wire logic [MON_CH-1:0] i_monitor_rx_event,
	input wire logic [MON_CH-1:0] i_monitor_tx_channel_flags,
	input wire logic [2:0] i_queue_full,
	input wire logic [LVL_W-1:0] i_rx_fifo_level,
	input wire logic [LVL_W-1:0] i_tx_fifo_level,
	input wire logic [LVL_W-1:0] i_event_fifo_level,
	input wire logic i_timer_event,
	input wire logic i_sequence_recovered,
	input wire logic [15:0] i_fault_count,
	input wire logic i_frame_sync,
	input wire logic i_mclk,
	input wire logic [15:0] i_initiate_block_base,
	output logic o_interrupt_output_pin,
	output logic o_timebase_tick,
	output logic [irq_queue_pkg::ADDR_W-1:0] o_line_status_queue_base,
	output logic [irq_queue_pkg::WORDS_W-1:0] o_line_status_queue_words,
	output logic [irq_queue_pkg::ADDR_W-1:0] o_monitor_queue_base,
	output logic [irq_queue_pkg::WORDS_W-1:0] o_monitor_queue_words,
	output logic [irq_queue_pkg::ADDR_W-1:0] o_ci_queue_base,
	output logic [irq_queue_pkg::WORDS_W-1:0] o_ci_queue_words
);
	import irq_queue_pkg::*;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	localparam logic [LVL_W-1:0] WARN_LEVEL = LVL_W'((FIFO_DEPTH * 3) / 4);
	localparam logic [LVL_W-1:0] FULL_LEVEL = LVL_W'(FIFO_DEPTH);

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	bus_state_t state_q;
	logic req_new;
	logic [IDX_W-1:0] idx;
	logic hit_qs;
	logic hit_es;
	logic hit_mask;
	logic [REG_W-1:0] queue_size_q;
	logic [REG_W-1:0] event_mask_q;
	logic [REG_W-1:0] lane_mask;
	logic seen_qs_write_q;
	event_flag_if #(.W(EVENT_BITS)) ev_bus();

	// a request is taken once, in the idle state
	assign req_new = i_wb_cyc && i_wb_stb && (state_q == BUS_IDLE);
	assign idx = i_wb_adr[ADR_W-1:2];
	assign hit_qs = (idx == IDX_QUEUE_SIZE);
	assign hit_es = (idx == IDX_EVENT_STATUS);
	assign hit_mask = (idx == IDX_EVENT_MASK);
	assign lane_mask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	assign o_wb_ack = (state_q == BUS_ACK);

	// ack always follows one cycle later, then drops
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= BUS_IDLE;
		end else begin
			unique case (state_q)
				BUS_IDLE: begin
					if (i_wb_cyc && i_wb_stb) begin
						state_q <= BUS_ACK;
					end
				end
				BUS_ACK: begin
					state_q <= BUS_IDLE;
				end
				default: begin
					state_q <= BUS_IDLE;
				end
			endcase
		end
	end

	// read data captured with the request; unmapped reads give zero
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wb_dat <= '0;
		end else if (req_new && !i_wb_we) begin
			if (hit_qs) begin
				o_wb_dat <= {16'h0000, queue_size_q};
			end else if (hit_es) begin
				o_wb_dat <= {16'h0000, 2'b00, ev_bus.flags};
			end else if (hit_mask) begin
				o_wb_dat <= {16'h0000, event_mask_q};
			end else begin
				o_wb_dat <= '0;
			end
		end
	end

	// queue size register, unused bits held at zero
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			queue_size_q <= QUEUE_SIZE_RESET;
		end else if (req_new && i_wb_we && hit_qs) begin
			queue_size_q <= ((i_wb_dat[REG_W-1:0] & lane_mask) | (queue_size_q & ~lane_mask))
				& QUEUE_SIZE_WMASK;
		end
	end

	// helper: remembers whether software has touched the size register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seen_qs_write_q <= 1'b0;
		end else if (req_new && i_wb_we && hit_qs) begin
			seen_qs_write_q <= 1'b1;
		end
	end

	// mask register, a one blocks that flag from the output
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			event_mask_q <= EVENT_MASK_RESET;
		end else if (req_new && i_wb_we && hit_mask) begin
			event_mask_q <= (i_wb_dat[REG_W-1:0] & lane_mask) | (event_mask_q & ~lane_mask);
		end
	end

	// ----------------------------------------
	// queue sizes and placement
	// ----------------------------------------
	logic [1:0] ci_queue_size_field;
	logic [2:0] monitor_queue_size_field;
	logic [2:0] line_status_queue_size_field;
	logic timebase_frame_sync_select;
	logic [WORDS_W-1:0] ci_words;
	logic [WORDS_W-1:0] mon_words;
	logic [WORDS_W-1:0] line_words;
	logic [ADDR_W-1:0] initiate_block_base;
	logic [ADDR_W-1:0] line_base;
	logic [ADDR_W-1:0] mon_base;

	assign ci_queue_size_field = queue_size_q[CI_LSB +: 2];
	assign monitor_queue_size_field = queue_size_q[MON_LSB +: 3];
	assign line_status_queue_size_field = queue_size_q[LINE_LSB +: 3];
	assign timebase_frame_sync_select = queue_size_q[TIMEBASE_SEL_BIT];

	// sizes grow in equal steps from the smallest code
	assign ci_words = WORDS_W'(CI_UNIT_WORDS * (WORDS_W'(ci_queue_size_field) + 11'h001));
	assign mon_words = WORDS_W'(QUEUE_UNIT_WORDS * (WORDS_W'(monitor_queue_size_field) + 11'h001));
	assign line_words = WORDS_W'(QUEUE_UNIT_WORDS * (WORDS_W'(line_status_queue_size_field) + 11'h001));

	// queues sit end to end above the initiate block
	assign initiate_block_base = {i_initiate_block_base, BASE_LOW_BYTE};
	assign line_base = initiate_block_base + QUEUE_AREA_OFFSET;
	assign mon_base = line_base + ADDR_W'(line_words);

	// placement outputs registered so downstream sees clean values
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_line_status_queue_base <= '0;
			o_line_status_queue_words <= '0;
			o_monitor_queue_base <= '0;
			o_monitor_queue_words <= '0;
			o_ci_queue_base <= '0;
			o_ci_queue_words <= '0;
		end else begin
			o_line_status_queue_base <= line_base;
			o_line_status_queue_words <= line_words;
			o_monitor_queue_base <= mon_base;
			o_monitor_queue_words <= mon_words;
			o_ci_queue_base <= mon_base + ADDR_W'(mon_words);
			o_ci_queue_words <= ci_words;
		end
	end

	// ----------------------------------------
	// time base
	// ----------------------------------------
	logic frame_sync_q;
	logic mclk_q;

	// edge detect on sampled inputs; one tick per rising edge of the selected source
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			frame_sync_q <= 1'b0;
			mclk_q <= 1'b0;
			o_timebase_tick <= 1'b0;
		end else begin
			frame_sync_q <= i_frame_sync;
			mclk_q <= i_mclk;
			if (timebase_frame_sync_select) begin
				o_timebase_tick <= i_frame_sync && !frame_sync_q;
			end else begin
				o_timebase_tick <= i_mclk && !mclk_q;
			end
		end
	end

	// ----------------------------------------
	// event sources
	// ----------------------------------------
	logic [MON_CH-1:0] mon_tx_prev_q;
	logic rx_warn_q;
	logic rx_full_q;
	logic tx_warn_q;
	logic tx_full_q;
	logic ev_warn_q;
	logic ev_full_q;
	logic fault_hit_q;
	logic rx_warn;
	logic rx_full;
	logic tx_warn;
	logic tx_full;
	logic ev_warn;
	logic ev_full;
	logic fault_hit;

	assign rx_warn = (i_rx_fifo_level >= WARN_LEVEL);
	assign rx_full = (i_rx_fifo_level >= FULL_LEVEL);
	assign tx_warn = (i_tx_fifo_level >= WARN_LEVEL);
	assign tx_full = (i_tx_fifo_level >= FULL_LEVEL);
	assign ev_warn = (i_event_fifo_level >= WARN_LEVEL);
	assign ev_full = (i_event_fifo_level >= FULL_LEVEL);
	assign fault_hit = (i_fault_count == FAULT_LIMIT);

	// previous states so each level crossing raises its flag once
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mon_tx_prev_q <= '0;
			rx_warn_q <= 1'b0;
			rx_full_q <= 1'b0;
			tx_warn_q <= 1'b0;
			tx_full_q <= 1'b0;
			ev_warn_q <= 1'b0;
			ev_full_q <= 1'b0;
			fault_hit_q <= 1'b0;
		end else begin
			mon_tx_prev_q <= i_monitor_tx_channel_flags;
			rx_warn_q <= rx_warn;
			rx_full_q <= rx_full;
			tx_warn_q <= tx_warn;
			tx_full_q <= tx_full;
			ev_warn_q <= ev_warn;
			ev_full_q <= ev_full;
			fault_hit_q <= fault_hit;
		end
	end

	// set requests; the status register itself is never a write target
	always_comb begin
		ev_bus.set_pulse = '0;
		ev_bus.set_pulse[EV_LINE] = |i_line_tx_event || |i_line_rx_event;
		ev_bus.set_pulse[EV_CI_RX] = |i_ci_rx_event;
		ev_bus.set_pulse[EV_MON_RX] = |i_monitor_rx_event;
		ev_bus.set_pulse[EV_MON_TX] = |(i_monitor_tx_channel_flags & ~mon_tx_prev_q);
		ev_bus.set_pulse[EV_CIRC] = |i_queue_full;
		ev_bus.set_pulse[EV_RX_WARN] = rx_warn && !rx_warn_q;
		ev_bus.set_pulse[EV_RX_OVL] = rx_full && !rx_full_q;
		ev_bus.set_pulse[EV_TX_WARN] = tx_warn && !tx_warn_q;
		ev_bus.set_pulse[EV_TX_OVL] = tx_full && !tx_full_q;
		ev_bus.set_pulse[EV_EV_WARN] = ev_warn && !ev_warn_q;
		ev_bus.set_pulse[EV_EV_OVL] = ev_full && !ev_full_q;
		ev_bus.set_pulse[EV_TIMER] = i_timer_event;
		ev_bus.set_pulse[EV_SEQ] = i_sequence_recovered;
		ev_bus.set_pulse[EV_FAULT] = fault_hit && !fault_hit_q;
	end

	// clear on the same edge that captures the read data
	assign ev_bus.clear_all = req_new && !i_wb_we && hit_es;

	event_flags #(.W(EVENT_BITS)) u_flags (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.flag_bus(ev_bus.keeper)
	);

	// ----------------------------------------
	// interrupt output
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_interrupt_output_pin <= 1'b0;
		end else begin
			o_interrupt_output_pin <= |(ev_bus.flags & ~event_mask_q[EVENT_BITS-1:0]);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_status_read;
		req_new && !i_wb_we && hit_es && (ev_bus.set_pulse == '0);
	endsequence

	sequence s_status_write;
		req_new && i_wb_we && hit_es && (ev_bus.set_pulse == '0) && !ev_bus.clear_all;
	endsequence

	a_ack_one_cycle: assert property (req_new |=> o_wb_ack ##1 !o_wb_ack)
		else $error("ack not a single cycle after request");

	a_read_clears: assert property (s_status_read |=> (ev_bus.flags == '0)
		&& (o_wb_dat[REG_W-1:0] == {2'b00, $past(ev_bus.flags)}))
		else $error("status read did not return then clear");

	a_status_ro: assert property (s_status_write |=> ev_bus.flags == $past(ev_bus.flags))
		else $error("write changed event status");

	a_irq_level: assert property (i_reset_n |=> o_interrupt_output_pin ==
		|($past(ev_bus.flags) & ~$past(event_mask_q[EVENT_BITS-1:0])))
		else $error("interrupt output does not follow unmasked flags");

	a_ci_size: assert property (i_reset_n |=> o_ci_queue_words ==
		WORDS_W'(11'h040 * (WORDS_W'($past(ci_queue_size_field)) + 11'h001)))
		else $error("command/indicate queue size wrong");

	a_mon_size: assert property (i_reset_n |=> o_monitor_queue_words ==
		{$past(monitor_queue_size_field) + 4'h1, 7'h00})
		else $error("monitor queue size wrong");

	a_line_size: assert property (i_reset_n |=> o_line_status_queue_words ==
		{$past(line_status_queue_size_field) + 4'h1, 7'h00})
		else $error("line status queue size wrong");

	a_queue_chain: assert property (i_reset_n |=> (o_line_status_queue_base ==
		{$past(i_initiate_block_base), 8'h00} + 24'h000100)
		&& (o_ci_queue_base == o_monitor_queue_base + ADDR_W'(o_monitor_queue_words)))
		else $error("queue placement wrong");

	a_tick_source: assert property (o_timebase_tick |->
		($past(timebase_frame_sync_select) ? ($past(i_frame_sync) && !$past(i_frame_sync, 2))
		: ($past(i_mclk) && !$past(i_mclk, 2))))
		else $error("time base ticked on the wrong source");

	a_size_reset: assert property (!seen_qs_write_q |-> queue_size_q == 16'h0000)
		else $error("queue size not zero before first write");

	a_fault_limit: assert property ((i_fault_count == 16'h00ff) && !fault_hit_q
		|=> ev_bus.flags[EV_FAULT])
		else $error("fault overload flag not raised");
endmodule

// ==== verification/event_source_model.sv ====
// Purpose: far-side event sources feeding the status block
// Assumes: one fire bit per flag, held for one cycle by the bench
// Notes: idle fifo levels and fault count are random but never cross a threshold
`timescale 1ns/1ps
module event_source_model (
	input wire logic i_clk,
	input wire logic [13:0] i_fire,
	output logic [31:0] o_line_tx_event,
	output logic [31:0] o_line_rx_event,
	output logic [15:0] o_ci_rx_event,
	output logic [15:0] o_monitor_rx_event,
	output logic [15:0] o_monitor_tx_channel_flags,
	output logic [2:0] o_queue_full,
	output logic [5:0] o_rx_fifo_level,
	output logic [5:0] o_tx_fifo_level,
	output logic [5:0] o_event_fifo_level,
	output logic o_timer_event,
	output logic o_sequence_recovered,
	output logic [15:0] o_fault_count
);
	logic [31:0] r;

	// ----------------------------------------
	// fifo level helper
	// ----------------------------------------
	// idle level stays below three quarters so only a fire can cross
	function automatic logic [5:0] level(input logic ovl, input logic warn, input logic [3:0] low);
		return ovl ? 6'h20 : (warn ? 6'h18 : {2'b00, low});
	endfunction

	// quiet sources before the first edge
	initial begin
		{o_line_tx_event, o_line_rx_event, o_ci_rx_event, o_monitor_rx_event} = '0;
		{o_monitor_tx_channel_flags, o_queue_full, o_rx_fifo_level, o_tx_fifo_level} = '0;
		{o_event_fifo_level, o_timer_event, o_sequence_recovered, o_fault_count} = '0;
	end

	// one random channel per fire, everything back to idle next cycle
	always @(posedge i_clk) begin
		r = $urandom;
		o_line_tx_event <= (i_fire[0] && r[5]) ? 32'h1 << r[4:0] : 32'h0;
		o_line_rx_event <= (i_fire[0] && !r[5]) ? 32'h1 << r[4:0] : 32'h0;
		o_ci_rx_event <= i_fire[1] ? 16'h1 << r[3:0] : 16'h0;
		o_monitor_rx_event <= i_fire[2] ? 16'h1 << r[7:4] : 16'h0;
		o_monitor_tx_channel_flags <= i_fire[3] ? 16'h1 << r[11:8] : 16'h0;
		o_queue_full <= i_fire[4] ? 3'h1 << (r[13:12] % 2'd3) : 3'h0;
		o_rx_fifo_level <= level(i_fire[6], i_fire[5], r[19:16]);
		o_tx_fifo_level <= level(i_fire[8], i_fire[7], r[23:20]);
		o_event_fifo_level <= level(i_fire[10], i_fire[9], r[27:24]);
		o_timer_event <= i_fire[11];
		o_sequence_recovered <= i_fire[12];
		o_fault_count <= i_fire[13] ? 16'h00ff : {9'h000, r[30:24]};
	end
endmodule

// ==== verification/irq_queue_status_bench.sv ====
// Purpose: self-checking bench for queue sizing and event status
// Assumes: reads are compared in order by a monitor process
// Notes: events come from event_source_model
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("BAD %0t got %h want %h", $time, g, e); end end
module irq_queue_status_bench;
	import irq_queue_pkg::*;
	logic i_clk = 0;
	logic i_reset_n = 0;
	logic cyc = 0, stb = 0, we = 0, fs = 0, mclk = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, exp_v;
	logic [3:0] sel = 4'h0;
	logic [13:0] fire = 14'h0;
	logic [15:0] seg = 16'h0, v, e_bits;
	logic ack, irq, tick;
	logic [31:0] ltx, lrx;
	logic [15:0] ci_rx, mon_rx, mon_tx, fc;
	logic [2:0] qf;
	logic [5:0] rxl, txl, evl;
	logic timer_ev, seq;
	logic [23:0] lb, mb, cb, base;
	logic [10:0] lw, mw, cw, elw, emw, ecw;
	logic [31:0] exp_q[$];
	int err_count = 0, check_count = 0, tick_n = 0, s;

	always #2 i_clk = ~i_clk;

	irq_queue_status dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_line_tx_event(ltx), .i_line_rx_event(lrx), .i_ci_rx_event(ci_rx), .i_monitor_rx_event(mon_rx),
		.i_monitor_tx_channel_flags(mon_tx), .i_queue_full(qf), .i_rx_fifo_level(rxl), .i_tx_fifo_level(txl),
		.i_event_fifo_level(evl), .i_timer_event(timer_ev), .i_sequence_recovered(seq), .i_fault_count(fc),
		.i_frame_sync(fs), .i_mclk(mclk), .i_initiate_block_base(seg), .o_interrupt_output_pin(irq),
		.o_timebase_tick(tick), .o_line_status_queue_base(lb), .o_line_status_queue_words(lw),
		.o_monitor_queue_base(mb), .o_monitor_queue_words(mw), .o_ci_queue_base(cb), .o_ci_queue_words(cw));

	event_source_model src_u (.i_clk(i_clk), .i_fire(fire), .o_line_tx_event(ltx), .o_line_rx_event(lrx),
		.o_ci_rx_event(ci_rx), .o_monitor_rx_event(mon_rx), .o_monitor_tx_channel_flags(mon_tx), .o_queue_full(qf),
		.o_rx_fifo_level(rxl), .o_tx_fifo_level(txl), .o_event_fifo_level(evl), .o_timer_event(timer_ev),
		.o_sequence_recovered(seq), .o_fault_count(fc));

	// ----------------------------------------
	// monitor: read data against oldest note
	// ----------------------------------------
	always @(posedge i_clk) begin
		if (ack === 1'b1 && !we) begin
			exp_v = exp_q.pop_front();
			`CHK(rdat, exp_v)
		end
		if (tick === 1'b1) begin
			tick_n++;
		end
	end

	// single classic cycle, held until ack is sampled; only the watchdog ends a hung wait
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		sel <= 4'h3;
		if (!w) begin
			exp_q.push_back({16'h0000, e});
		end
		do begin
			@(posedge i_clk);
		end while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// one-cycle fire, then time for flag and output to settle
	task automatic fire_one(input int b);
		@(posedge i_clk);
		fire <= 14'h1 << b;
		@(posedge i_clk);
		fire <= 14'h0;
		repeat (6) @(posedge i_clk);
	endtask

	task automatic pulse(input logic on_fs);
		@(posedge i_clk);
		if (on_fs) begin
			fs <= 1'b1;
		end else begin
			mclk <= 1'b1;
		end
		repeat (3) @(posedge i_clk);
		fs <= 1'b0;
		mclk <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles needed
	initial begin
		#100000;
		err_count++;
		stop_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		s = $urandom(86);
		repeat (5) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		`CHK(cw, 11'h040)
		`CHK(lw, 11'h080)
		wb(1'b0, 8'hd8, 16'h0, 16'h0000);
		wb(1'b0, 8'he0, 16'h0, 16'h0000);
		wb(1'b1, 8'he8, 16'h0000, 16'h0);
		// every flag alone; overload crossings also pass the warning level
		for (int b = 0; b < 14; b++) begin
			fire_one(b);
			`CHK(irq, 1'b1)
			e_bits = 16'h1 << b;
			if (b == 6 || b == 8 || b == 10) e_bits |= 16'h1 << (b - 1);
			wb(1'b0, 8'he0, 16'h0, e_bits);
			wb(1'b0, 8'he0, 16'h0, 16'h0000);
			repeat (3) @(posedge i_clk);
			`CHK(irq, 1'b0)
		end
		// masked flag stays quiet; writes to status are ignored
		wb(1'b1, 8'he8, 16'hffff, 16'h0);
		fire_one(11);
		`CHK(irq, 1'b0)
		wb(1'b1, 8'he0, 16'hf7ff, 16'h0);
		wb(1'b0, 8'he0, 16'h0, 16'h0800);
		wb(1'b1, 8'he8, 16'hf7ff, 16'h0);
		fire_one(11);
		`CHK(irq, 1'b1)
		wb(1'b0, 8'he0, 16'h0, 16'h0800);
		wb(1'b1, 8'hf0, 16'hffff, 16'h0);
		wb(1'b0, 8'hf0, 16'h0, 16'h0000);
		// all size codes, both time base sources
		for (int i = 0; i < 8; i++) begin
			seg <= 16'($urandom);
			v = {i[0], 7'h00, i[2:0], 3'(7 - i), 2'(i)};
			wb(1'b1, 8'hd8, v ^ 16'h7f00, 16'h0);
			wb(1'b0, 8'hd8, 16'h0, v);
			repeat (2) @(posedge i_clk);
			elw = 11'((i + 1) * 128);
			emw = 11'((8 - i) * 128);
			ecw = 11'((i % 4 + 1) * 64);
			base = {seg, 8'h00} + 24'h000100;
			`CHK(lw, elw)
			`CHK(mw, emw)
			`CHK(cw, ecw)
			`CHK(lb, base)
			`CHK(mb, base + 24'(elw))
			`CHK(cb, base + 24'(elw) + 24'(emw))
			tick_n = 0;
			pulse(1'b0);
			`CHK(tick_n, (i[0] ? 0 : 1))
			tick_n = 0;
			pulse(1'b1);
			`CHK(tick_n, (i[0] ? 1 : 0))
		end
		// reset in mid-run drops a pending flag, sizes and mask to their reset values
		fire_one(11);
		`CHK(irq, 1'b1)
		i_reset_n <= 1'b0;
		repeat (5) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		`CHK(irq, 1'b0)
		`CHK(mw, 11'h080)
		wb(1'b0, 8'hd8, 16'h0, QUEUE_SIZE_RESET);
		wb(1'b0, 8'he0, 16'h0, 16'h0000);
		wb(1'b0, 8'he8, 16'h0, EVENT_MASK_RESET);
		stop_test();
	end
endmodule
